/* hdl/fsp_pkg.sv */
// Constants, types and carriers for the flash segment protection map.
`default_nettype none

package fsp_pkg;

  // ----------------------------------------------------------------
  // Flash segment boundaries (instruction word addresses, step of 2)
  // ----------------------------------------------------------------
  localparam int unsigned AW = 24;
  localparam logic [23:0] VS_LAST       = 24'h0001fe;
  localparam logic [23:0] BS_FIRST      = 24'h000200;
  localparam logic [23:0] LAST_32K      = 24'h0057fe;
  localparam logic [23:0] LAST_16K      = 24'h002bfe;
  // Boot segment sizes in instruction words: 768, 3840, 7936, 5376.
  localparam logic [23:0] BW_SMALL      = 24'h000300;
  localparam logic [23:0] BW_MEDIUM     = 24'h000f00;
  localparam logic [23:0] BW_LARGE_32K  = 24'h001f00;
  localparam logic [23:0] BW_LARGE_16K  = 24'h001500;
  localparam logic [23:0] BW_NONE       = 24'h000000;

  // ----------------------------------------------------------------
  // Boot size field codes (low two bits) and pin pair codes
  // ----------------------------------------------------------------
  localparam logic [1:0] BSS_NONE   = 2'h3;
  localparam logic [1:0] BSS_SMALL  = 2'h2;
  localparam logic [1:0] BSS_MEDIUM = 2'h1;
  localparam logic [1:0] BSS_LARGE  = 2'h0;
  localparam logic [1:0] CH_PAIR1   = 2'h3;
  localparam logic [1:0] CH_PAIR2   = 2'h2;
  localparam logic [1:0] CH_PAIR3   = 2'h1;
  localparam logic [1:0] CH_RSVD    = 2'h0;

  // ----------------------------------------------------------------
  // Register offsets, field positions, masks and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_BOOT_CFG = 4'h0;
  localparam logic [3:0] OFS_GEN_CFG  = 4'h1;
  localparam logic [3:0] OFS_DBG_CTRL = 4'h2;
  localparam logic [3:0] OFS_TX_DATA  = 4'h3;
  localparam logic [3:0] OFS_RX_DATA  = 4'h4;
  localparam logic [3:0] OFS_STATUS   = 4'h5;
  localparam int unsigned F_WP_N   = 0;
  localparam int unsigned F_BSS_LO = 1;
  localparam int unsigned F_BSS_HI = 3;
  localparam int unsigned F_BCP_N  = 4;
  localparam int unsigned F_GCP_N  = 1;
  localparam int unsigned F_CH_LO  = 0;
  localparam int unsigned F_CH_HI  = 1;
  localparam int unsigned F_DBG_EN = 2;
  localparam int unsigned F_SIZE16 = 3;
  localparam logic [7:0] BOOT_CFG_MASK = 8'h1f;
  localparam logic [7:0] GEN_CFG_MASK  = 8'h03;
  localparam logic [7:0] DBG_MASK      = 8'h0f;
  localparam logic [7:0] BOOT_CFG_RST  = 8'h1f;
  localparam logic [7:0] GEN_CFG_RST   = 8'h03;
  localparam logic [7:0] DBG_RST       = 8'h03;
  localparam logic [15:0] DBG_RAM_BYTES = 16'h0050;
  localparam logic [3:0] TX_BITS        = 4'h8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEG_NONE,
    SEG_VECTOR,
    SEG_BOOT,
    SEG_GENERAL
  } fsp_seg_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } fsp_bus_s;

  typedef struct packed {
    logic [2:0] clk;
    logic [2:0] dat;
  } fsp_pin_in_s;

  typedef struct packed {
    logic [2:0] dat;
    logic [2:0] oe;
  } fsp_pin_out_s;

endpackage

`default_nettype wire

/* hdl/fsp_map.sv */
// Flash segment map, protection lookup and programming/debug pin port.
//
// The address map and strobed register access are this design's own decisions.
`default_nettype none

module fsp_map (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire fsp_pkg::fsp_bus_s    i_bus,
  output logic [7:0]                o_rdata,
  input  wire logic [23:0]          i_flash_addr,
  output fsp_pkg::fsp_seg_e         o_segment,
  output logic                      o_write_protect,
  output logic                      o_read_protect,
  input  wire logic [15:0]          i_data_addr,
  output logic                      o_data_reserved,
  output logic [2:0]                o_pin_reserved,
  input  wire fsp_pkg::fsp_pin_in_s i_pins,
  output fsp_pkg::fsp_pin_out_s     o_pins,
  input  wire logic                 i_master_clear_pin_n
);
  import fsp_pkg::*;

  // ----------------------------------------------------------------
  // Block state
  // ----------------------------------------------------------------

  // All state of the block lives in one packed struct.
  // The combinational process builds the next copy from the current one.
  // The clocked process only registers that copy or loads reset values.
  // Keeping everything in one struct makes each output a plain flop.
  // Configuration fields sit at the top of the struct.
  // They reset to the erased level: all protection off, pair one, debug off.
  // The pin synchronisers come next, two stages per pin.
  // Only the second stage is ever read by the link logic.
  // This guards against metastability on pins that the far side drives.
  // The link clock is a plain input sampled by the system clock.
  // Its edges are found by comparing the synchronised level with clk_prev.
  // A link clock must therefore stay well below half the system clock.
  typedef struct packed {
    logic [7:0]   boot_cfg;
    logic [7:0]   gen_cfg;
    logic [7:0]   dbg_ctrl;
    fsp_pin_in_s  pin_s1;
    fsp_pin_in_s  pin_s2;
    logic         master_clear_pin_s1;
    logic         master_clear_pin_s2;
    logic         clk_prev;
    logic [7:0]   rx_sr;
    logic [2:0]   rx_cnt;
    logic [7:0]   rx_byte;
    logic         rx_valid;
    logic [7:0]   tx_sr;
    logic [3:0]   tx_cnt;
    logic         tx_busy;
    fsp_pin_out_s pins;
    fsp_seg_e     seg;
    logic         wp;
    logic         rp;
    logic         data_res;
    logic [2:0]   pin_res;
    logic [7:0]   rdata;
  } fsp_state_s;

  fsp_state_s st_q;
  fsp_state_s st_d;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Segment sizes are counted in instruction words.
  // Word addresses step by two, so a word count is doubled into addresses.
  // The boot segment always starts just above the vector segment.
  // Its end is found by adding the doubled length to that start.
  // Only the low two bits of the size code select a length.
  // The top bit of the code field is stored but has no effect here.
  // The large size code selects a different length on each of the two array sizes.
  // On the small array the largest boot segment fills the whole array above the vector segment.
  // Classification checks vector first, then boot, then general.
  // Anything beyond the array end falls into no segment at all.
  // Such words are reported fully protected so nothing can touch them.

  // Boot segment length in words for the array size and size code.
  function automatic logic [23:0] boot_words(input logic size16,
                                             input logic [1:0] bss);
    logic [23:0] w;
    w = BW_NONE;
    unique case (bss)
      BSS_NONE:   w = BW_NONE;
      BSS_SMALL:  w = BW_SMALL;
      BSS_MEDIUM: w = BW_MEDIUM;
      BSS_LARGE:  w = size16 ? BW_LARGE_16K : BW_LARGE_32K;
    endcase
    return w;
  endfunction

  // Classifies one word address against the configured boundaries.
  function automatic fsp_seg_e classify(input logic [23:0] addr,
                                        input logic size16,
                                        input logic [1:0] bss);
    logic [23:0] boot_end;
    logic [23:0] last;
    logic [23:0] bw;
    fsp_seg_e    s;
    bw       = boot_words(size16, bss);
    boot_end = BS_FIRST + {bw[22:0], 1'b0};
    last     = size16 ? LAST_16K : LAST_32K;
    if (addr <= VS_LAST)
      s = SEG_VECTOR;
    else if (addr < boot_end)
      s = SEG_BOOT;
    else if (addr <= last)
      s = SEG_GENERAL;
    else
      s = SEG_NONE;
    return s;
  endfunction

  // Maps the channel code to a one-hot pin pair; the unused code gives none.
  function automatic logic [2:0] pair_onehot(input logic [1:0] ch);
    logic [2:0] oh;
    oh = 3'h0;
    unique case (ch)
      CH_PAIR1: oh = 3'h1;
      CH_PAIR2: oh = 3'h2;
      CH_PAIR3: oh = 3'h4;
      CH_RSVD:  oh = 3'h0;
    endcase
    return oh;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // The link runs only while master clear is high and a pair is chosen.
  // The reserved channel code selects no pair, so the link stays idle.
  // Dropping master clear clears a half received byte.
  // It also aborts a transmit in flight and releases the data pin.
  // The link is half duplex: no bit is taken in while transmitting.
  // Receive shifts on rising link clock edges, most significant bit first.
  // Transmit changes the data pin on falling link clock edges.
  // That leaves the far side a full half period to sample each bit.
  // After the last bit the next falling edge releases the pin.
  // A transmit write while busy or while the link is off is ignored.
  // A received byte and a read of it in one cycle leave the flag set.
  // Register reads answer in the following cycle and read zero otherwise.
  logic [2:0] sel;
  logic       sel_clk;
  logic       sel_dat;
  logic       rise;
  logic       fall;
  logic       link_on;
  logic       dbg_en;
  logic       size16;
  logic       rx_done;

  // Decodes fields, runs the pin link and the register port.
  always_comb
  begin
    st_d    = st_q;
    dbg_en  = st_q.dbg_ctrl[F_DBG_EN];
    size16  = st_q.dbg_ctrl[F_SIZE16];
    sel     = pair_onehot(st_q.dbg_ctrl[F_CH_HI:F_CH_LO]);
    sel_clk = |(sel & st_q.pin_s2.clk);
    sel_dat = |(sel & st_q.pin_s2.dat);
    link_on = st_q.master_clear_pin_s2 && (sel != 3'h0);
    rise    = link_on && sel_clk && !st_q.clk_prev;
    fall    = link_on && !sel_clk && st_q.clk_prev;
    rx_done = 1'b0;

    // Two-stage synchronisers for every pin; stage one feeds only stage two.
    st_d.pin_s1  = i_pins;
    st_d.pin_s2  = st_q.pin_s1;
    st_d.master_clear_pin_s1 = i_master_clear_pin_n;
    st_d.master_clear_pin_s2 = st_q.master_clear_pin_s1;
    st_d.clk_prev = sel_clk;

    // Receive: sample data on rising clock edges, MSB first, while idle.
    if (!link_on)
    begin
      st_d.rx_cnt = 3'h0;
    end
    else if (rise && !st_q.tx_busy)
    begin
      st_d.rx_sr  = {st_q.rx_sr[6:0], sel_dat};
      st_d.rx_cnt = st_q.rx_cnt + 3'h1;
      if (st_q.rx_cnt == 3'h7)
      begin
        st_d.rx_byte = {st_q.rx_sr[6:0], sel_dat};
        rx_done      = 1'b1;
      end
    end

    // Transmit: present the next bit on each falling clock edge.
    if (!link_on)
    begin
      st_d.tx_busy = 1'b0;
      st_d.tx_cnt  = 4'h0;
    end
    else if (fall && st_q.tx_busy)
    begin
      if (st_q.tx_cnt == 4'h0)
        st_d.tx_busy = 1'b0;                         // Release after last bit.
      else
      begin
        st_d.pins.dat = {3{st_q.tx_sr[7]}} & sel;
        st_d.tx_sr    = {st_q.tx_sr[6:0], 1'b0};
        st_d.tx_cnt   = st_q.tx_cnt - 4'h1;
      end
    end
    st_d.pins.oe = st_d.tx_busy ? sel : 3'h0;

    // Register writes; a transmit write while busy is ignored.
    if (i_bus.we)
    begin
      unique case (i_bus.addr)
        OFS_BOOT_CFG: st_d.boot_cfg = i_bus.wdata & BOOT_CFG_MASK;
        OFS_GEN_CFG:  st_d.gen_cfg  = i_bus.wdata & GEN_CFG_MASK;
        OFS_DBG_CTRL: st_d.dbg_ctrl = i_bus.wdata & DBG_MASK;
        OFS_TX_DATA:
        begin
          if (!st_q.tx_busy && link_on)
          begin
            st_d.tx_sr   = i_bus.wdata;
            st_d.tx_cnt  = TX_BITS;
            st_d.tx_busy = 1'b1;
            st_d.pins.oe = sel;
          end
        end
        default: ;
      endcase
    end

    // Register reads; reading received data clears its flag, a new byte wins.
    st_d.rdata = 8'h00;
    if (i_bus.re)
    begin
      unique case (i_bus.addr)
        OFS_BOOT_CFG: st_d.rdata = st_q.boot_cfg;
        OFS_GEN_CFG:  st_d.rdata = st_q.gen_cfg;
        OFS_DBG_CTRL: st_d.rdata = st_q.dbg_ctrl;
        OFS_RX_DATA:
        begin
          st_d.rdata    = st_q.rx_byte;
          st_d.rx_valid = 1'b0;
        end
        OFS_STATUS:
          st_d.rdata = {2'b00, st_q.seg, st_q.master_clear_pin_s2, (sel == 3'h0),
                        st_q.tx_busy, st_q.rx_valid};
        default: st_d.rdata = 8'h00;
      endcase
    end
    if (rx_done)
      st_d.rx_valid = 1'b1;

    // Segment class and protection of the presented flash address.
    st_d.seg = classify(i_flash_addr, size16,
                        st_q.boot_cfg[F_BSS_LO+1:F_BSS_LO]);
    unique case (st_d.seg)
      SEG_BOOT:
      begin
        st_d.wp = !st_q.boot_cfg[F_WP_N];
        st_d.rp = !st_q.boot_cfg[F_BCP_N];
      end
      SEG_VECTOR, SEG_GENERAL:
      begin
        st_d.wp = !st_q.gen_cfg[F_WP_N];
        st_d.rp = !st_q.gen_cfg[F_GCP_N];
      end
      SEG_NONE:
      begin
        st_d.wp = 1'b1;
        st_d.rp = 1'b1;
      end
    endcase

    // Resources withheld while debugging is enabled.
    st_d.data_res = dbg_en && (i_data_addr < DBG_RAM_BYTES);
    st_d.pin_res  = dbg_en ? sel : 3'h0;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Reset is synchronous and loads constants only.
  // The segment output starts as vector, which matches address zero.
  // The first edge after release shows the class of the presented address.
  // All pins are released and all reserved flags are low after reset.
  // Synchroniser stages reset low, so master clear reads low for two cycles.
  // No link edge can be seen until the stages hold real pin levels.

  // Registers the whole state; reset restores erased configuration.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_q          <= '0;
      st_q.boot_cfg <= BOOT_CFG_RST;
      st_q.gen_cfg  <= GEN_CFG_RST;
      st_q.dbg_ctrl <= DBG_RST;
      st_q.seg      <= SEG_VECTOR;
    end
    else
      st_q <= st_d;
  end

  // ----------------------------------------------------------------
  // Outputs, all taken from the state register
  // ----------------------------------------------------------------

  // Every output comes straight from a flop of the state register.
  // Lookups therefore answer one cycle after the address is presented.
  // Users that need a same-cycle answer must present addresses early.
  // Drives the ports from the registered state.
  assign o_rdata         = st_q.rdata;
  assign o_segment       = st_q.seg;
  assign o_write_protect = st_q.wp;
  assign o_read_protect  = st_q.rp;
  assign o_data_reserved = st_q.data_res;
  assign o_pin_reserved  = st_q.pin_res;
  assign o_pins          = st_q.pins;

endmodule

`default_nettype wire

/* sim/fsp_map_properties.sv */
// Concurrent checks on the ports of the flash segment map.
`default_nettype none
module fsp_map_properties (
  input wire logic                 i_clk,
  input wire logic                 i_rst,
  input wire fsp_pkg::fsp_bus_s    i_bus,
  input wire logic [7:0]           o_rdata,
  input wire logic [23:0]          i_flash_addr,
  input wire fsp_pkg::fsp_seg_e    o_segment,
  input wire logic                 o_write_protect,
  input wire logic                 o_read_protect,
  input wire logic [15:0]          i_data_addr,
  input wire logic                 o_data_reserved,
  input wire logic [2:0]           o_pin_reserved,
  input wire fsp_pkg::fsp_pin_out_s o_pins,
  input wire logic                 i_master_clear_pin_n
);
  import fsp_pkg::*;
  // -----------------------------------------------------------------
  // Checks, all on the system clock and disabled during reset.
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  vec_seg_a:
    assert property (i_flash_addr <= 24'h0001fe |=> o_segment == SEG_VECTOR)
    else $error("vector class wrong");
  boot_start_a:
    assert property (i_flash_addr == 24'h000200 |=> o_segment inside {SEG_BOOT, SEG_GENERAL})
    else $error("word 200h misclassed");
  past_end_a:
    assert property (i_flash_addr > 24'h0057fe |=> o_segment == SEG_NONE)
    else $error("address past array not NONE");
  none_prot_a:
    assert property (o_segment == SEG_NONE |-> o_write_protect && o_read_protect)
    else $error("unmapped word unprotected");
  data_rsvd_a:
    assert property (o_data_reserved |-> $past(i_data_addr) < 16'h0050)
    else $error("RAM reserved above 80 bytes");
  pin_rsvd_a:
    assert property ($onehot0(o_pin_reserved))
    else $error("more than one pair withheld");
  oe_pair_a:
    assert property ($onehot0(o_pins.oe))
    else $error("more than one pair driven");
  master_clear_pin_abort_a:
    assert property ($fell(i_master_clear_pin_n) |-> ##[1:6] (o_pins.oe == 3'h0))
    else $error("master clear did not stop driving");
  rdata_idle_a:
    assert property (!$past(i_bus.re) |-> o_rdata == 8'h00)
    else $error("read data outside read cycle");
  // Main scenarios reached.
  cover property (o_pins.oe != 3'h0);
  cover property (o_data_reserved);
  cover property (o_segment == SEG_BOOT);
endmodule
bind fsp_map fsp_map_properties fsp_map_properties_inst (.i_clk, .i_rst, .i_bus, .o_rdata,
  .i_flash_addr, .o_segment, .o_write_protect, .o_read_protect, .i_data_addr,
  .o_data_reserved, .o_pin_reserved, .o_pins, .i_master_clear_pin_n);
`default_nettype wire

/* sim/fsp_prog_model.sv */
// Behavioural serial programmer on the far side of the debug pins.
`default_nettype none
module fsp_prog_model (
  output logic [2:0]      o_clk,
  output logic [2:0]      o_dat,
  output logic            o_master_clear_pin_n,
  input  wire logic [2:0] i_dat
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle: clocks stand low, master clear released high.
  initial
  begin
    o_clk = 3'h0;
    o_dat = 3'h0;
    o_master_clear_pin_n = 1'b1;
  end
  // Drives the master clear line.
  task automatic set_master_clear_pin(input logic v);
    o_master_clear_pin_n <= v;
  endtask
  // Sends the top n bits, MSB first, data set while the clock is low.
  task automatic send(input int p, input int n, input logic [7:0] b);
    #13;
    for (int i = 7; i > 7 - n; i--)
    begin
      o_dat[p] = b[i];
      #200 o_clk[p] = 1'b1;
      #200 o_clk[p] = 1'b0;
    end
    o_dat[p] = ~b[8 - n];
  endtask
  // Clocks a byte out; the device changes bits on falling edges.
  task automatic recv(input int p, output logic [7:0] b);
    #13 o_clk[p] = 1'b1;
    #200;
    for (int i = 7; i >= 0; i--)
    begin
      o_clk[p] = 1'b0;
      #200 o_clk[p] = 1'b1;
      #180 b[i] = i_dat[p];
      #20;
    end
    o_clk[p] = 1'b0;
    #400;
  endtask
endmodule
`default_nettype wire

/* sim/fsp_map_test.sv */
// Self-checking bench for the flash segment map and its debug pins.
`default_nettype none
module fsp_map_test;
  timeunit 1ns;
  timeprecision 1ns;
  import fsp_pkg::*;
  localparam int BW [2][4] = '{'{7936, 3840, 768, 0}, '{5376, 3840, 768, 0}};
  localparam logic [1:0] CD [3] = '{CH_PAIR1, CH_PAIR2, CH_PAIR3};
  localparam logic [2:0] OH [3] = '{3'h1, 3'h2, 3'h4};
  logic         i_clk;
  logic         i_rst;
  fsp_bus_s     bus;
  logic [7:0]   rdata;
  logic [23:0]  faddr;
  fsp_seg_e     seg;
  logic         wp;
  logic         rp;
  logic [15:0]  daddr;
  logic         drsv;
  logic [2:0]   prsv;
  fsp_pin_in_s  pin_i;
  fsp_pin_out_s pin_o;
  logic [2:0]   m_clk;
  logic [2:0]   m_dat;
  logic         master_clear_pin_n;
  logic [7:0]   v;
  int           errors;
  int           cmp_count;
  // Wire level of each data pin: the device drives where its enable is set, the model elsewhere.
  assign pin_i = {m_clk, (pin_o.oe & pin_o.dat) | (~pin_o.oe & m_dat)};
  fsp_map fsp_map_inst (.i_clk(i_clk), .i_rst(i_rst), .i_bus(bus), .o_rdata(rdata),
    .i_flash_addr(faddr), .o_segment(seg), .o_write_protect(wp), .o_read_protect(rp),
    .i_data_addr(daddr), .o_data_reserved(drsv), .o_pin_reserved(prsv), .i_pins(pin_i),
    .o_pins(pin_o), .i_master_clear_pin_n(master_clear_pin_n));
  fsp_prog_model fsp_prog_model_inst (.o_clk(m_clk), .o_dat(m_dat), .o_master_clear_pin_n(master_clear_pin_n),
    .i_dat(pin_i.dat));
  // System clock, 50 ns period.
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares=%0d mismatches=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.we <= 1'b1;
    @(posedge i_clk);
    bus.we <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk);
    bus.addr <= a;
    bus.re <= 1'b1;
    @(posedge i_clk);
    bus.re <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic look(input logic [23:0] a, input fsp_seg_e e);
    @(posedge i_clk);
    faddr <= a;
    @(posedge i_clk);
    #1 chk(seg, e);
  endtask
  // Reset values and an unmapped offset.
  task automatic t_regs();
    rdc(OFS_BOOT_CFG, BOOT_CFG_RST);
    rdc(OFS_GEN_CFG, GEN_CFG_RST);
    rdc(OFS_DBG_CTRL, DBG_RST);
    wr(4'hf, 8'hff);
    rdc(4'hf, 8'h00);
    $display("regs done");
  endtask
  // Segment edges for both array sizes and all size codes.
  task automatic t_map();
    logic [23:0] last;
    logic [23:0] be;
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 4; c++)
      begin
        last = (s != 0) ? 24'h002bfe : 24'h0057fe;
        be = 24'h0001fe + 24'(2 * BW[s][c]);
        wr(OFS_DBG_CTRL, (s != 0) ? 8'h0b : 8'h03);
        wr(OFS_BOOT_CFG, 8'h11 | 8'(c << 1));
        look(24'h0001fe, SEG_VECTOR);
        look(24'h000200, (BW[s][c] != 0) ? SEG_BOOT : SEG_GENERAL);
        look(be, (BW[s][c] != 0) ? SEG_BOOT : SEG_VECTOR);
        look(be + 24'h2, (be < last) ? SEG_GENERAL : SEG_NONE);
        look(last, (be < last) ? SEG_GENERAL : SEG_BOOT);
        look(last + 24'h2, SEG_NONE);
      end
    $display("map done");
  endtask
  // Write and code protection from the two configuration registers.
  task automatic t_prot();
    wr(OFS_DBG_CTRL, 8'h03);
    wr(OFS_BOOT_CFG, 8'h14);
    wr(OFS_GEN_CFG, 8'h01);
    look(24'h000200, SEG_BOOT);
    chk({wp, rp}, 2'b10);
    look(24'h000800, SEG_GENERAL);
    chk({wp, rp}, 2'b01);
    look(24'h000000, SEG_VECTOR);
    chk({wp, rp}, 2'b01);
    wr(OFS_GEN_CFG, GEN_CFG_RST);
    $display("prot done");
  endtask
  // Withheld RAM and pins while debug is on, per channel code.
  task automatic t_dbg();
    for (int p = 0; p < 3; p++)
    begin
      wr(OFS_DBG_CTRL, {6'h01, CD[p]});
      daddr <= 16'h004f;
      @(posedge i_clk);
      #1 chk({prsv, drsv}, {OH[p], 1'b1});
      @(posedge i_clk);
      daddr <= 16'h0050;
      @(posedge i_clk);
      #1 chk(drsv, 1'b0);
    end
    wr(OFS_DBG_CTRL, 8'h03);
    daddr <= 16'h0000;
    @(posedge i_clk);
    #1 chk({prsv, drsv}, 4'h0);
    $display("dbg done");
  endtask
  // A byte in and a byte out on each pin pair.
  task automatic t_link();
    for (int p = 0; p < 3; p++)
    begin
      wr(OFS_DBG_CTRL, {6'h00, CD[p]});
      fsp_prog_model_inst.send(p, 8, 8'hc5 ^ 8'(p));
      repeat (8) @(posedge i_clk);
      rdc(OFS_STATUS, 8'h19);
      rdc(OFS_RX_DATA, 8'hc5 ^ 8'(p));
      wr(OFS_TX_DATA, 8'h3a + 8'(p));
      rdc(OFS_STATUS, 8'h1a);
      @(posedge i_clk);
      #1 chk(pin_o.oe, OH[p]);
      fsp_prog_model_inst.recv(p, v);
      chk(v, 8'h3a + 8'(p));
      chk(pin_o.oe, 3'h0);
    end
    $display("link done");
  endtask
  // Master clear drops a half byte and a transmit in flight.
  task automatic t_abort();
    wr(OFS_DBG_CTRL, 8'h03);
    fsp_prog_model_inst.send(0, 4, 8'ha0);
    wr(OFS_TX_DATA, 8'h81);
    repeat (4) @(posedge i_clk);
    fsp_prog_model_inst.set_master_clear_pin(1'b0);
    repeat (8) @(posedge i_clk);
    #1 chk(pin_o.oe, 3'h0);
    fsp_prog_model_inst.set_master_clear_pin(1'b1);
    repeat (8) @(posedge i_clk);
    fsp_prog_model_inst.send(0, 8, 8'h5a);
    repeat (8) @(posedge i_clk);
    rdc(OFS_RX_DATA, 8'h5a);
    $display("abort done");
  endtask
  // Main sequence: reset for five cycles, then every scenario.
  initial
  begin
    errors = 0;
    cmp_count = 0;
    bus = '0;
    faddr = '0;
    daddr = '0;
    i_rst = 1'b1;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs();
    t_map();
    t_prot();
    t_dbg();
    t_link();
    t_abort();
    give_verdict();
  end
  // Watchdog well beyond the expected run of about 40 us.
  initial
  begin
    #500000;
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
